// file: hw/ttfm_hyst_flag.sv
// Hysteresis fault flag: set at one threshold, released at another
`timescale 1ns/1ps
`default_nettype none

module ttfm_hyst_flag (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic upd, // Sample strobe
  input wire logic set_cond, // Fault threshold reached
  input wire logic clr_cond, // Release threshold passed
  output logic flag // Fault flag, registered
);

  // Set beats release, so a tripping sample is never lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (ce && upd) begin
      if (set_cond) begin
        flag <= 1'b1;
      end else if (clr_cond) begin
        flag <= 1'b0;
      end
    end
  end

  chk_flag_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (flag && !(ce && upd && clr_cond && !set_cond)) |=> flag)
    else $error("fault flag dropped without release");

  chk_flag_trip: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && upd && set_cond) |=> flag)
    else $error("fault flag missed its threshold");

endmodule

`default_nettype wire

// file: hw/ttfm_monitor.sv
// Temperature and gate-driver-supply limit monitor with fault response
// Overview of operation
// - Retry code 000 holds output off until cleared
// - Retry code 111 restarts endlessly until stopped
// - Restart spacing: (delay field + 1) x 35 ms
// - Policy byte reserved bits always hold 10
// - Over-temp warning sets status bits, alerts host
// - Under-temp warning sets status bits, alerts host
// - Under-temp fault clears above under-temp warning
// - Under-temp fault follows its writable policy byte
// - Driver overvoltage fault threshold fixed, read-only
// - Shared overvoltage policy reads fixed 80h
// - Driver overvoltage warning sets status, alerts host
// - Driver undervoltage warning sets status, alerts host
// - Driver undervoltage fault clears above warning threshold
// - Driver undervoltage fault threshold fixed, read-only
// - Over-temp fault clears below over-temp warning
`timescale 1ns/1ps
`default_nettype none

module ttfm_monitor
  import ttfm_pkg::*;
#(
  parameter int RETRY_UNIT_CYC = RETRY_UNIT_CYC_DEF, // Cycles per 35 ms
  parameter int CNT_W = RETRY_CNT_W, // Retry counter width
  parameter logic [15:0] OT_FAULT_THR = OT_FAULT_THR_DEF // OT fault level
) (
  input wire logic clk, // 50 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire ttfm_cmd_t cmd, // Command code, strobes, write data
  output logic [15:0] cmd_rdata, // Read data, registered
  output logic cmd_nack, // Rejected command, registered pulse
  input wire logic meas_valid, // New measurement sample strobe
  input wire logic [15:0] temp_meas, // Temperature, linear-11
  input wire logic [15:0] drv_meas, // Driver supply, linear-11
  input wire logic run_en, // On command, pin and operation
  output logic output_en, // Power stage enable, registered
  output logic [NFLT-1:0] fault_active, // Fault flags, registered
  output logic alert_n // Host alert, active low
);

  // Writable limits and policies
  logic [15:0] otw_reg, utw_reg, utf_reg;
  ttfm_policy_t ut_pol_reg, ot_pol_reg;

  // Sticky status and summaries
  logic [ST_W-1:0] st_temp_reg, st_drv_reg, temp_ev, drv_ev;
  logic [15:0] status_word;
  logic alert_reg;
  logic clr_cmd;

  // Read path
  logic [15:0] rd_val;
  logic rd_hit, wr_ok;

  // Comparison operands
  logic signed [FIX_W-1:0] t_fix, d_fix;
  logic signed [FIX_W-1:0] otw_fix, utw_fix, utf_fix, otf_fix;
  logic signed [FIX_W-1:0] dovf_fix, dovw_fix, duvw_fix, duvf_fix;
  logic otw_hit, utw_hit, dovw_hit, duvw_hit;

  // Fault channels
  logic [NFLT-1:0] flt_set, flt_clr, run_ok, blk;
  ttfm_policy_t pol [NFLT];

  // Linear-11 to common fixed point so limits compare directly
  assign t_fix = ttfm_l11_fix(temp_meas);
  assign d_fix = ttfm_l11_fix(drv_meas);
  assign otw_fix = ttfm_l11_fix(otw_reg);
  assign utw_fix = ttfm_l11_fix(utw_reg);
  assign utf_fix = ttfm_l11_fix(utf_reg);
  assign otf_fix = ttfm_l11_fix(OT_FAULT_THR);
  assign dovf_fix = ttfm_l11_fix(DOV_FLT_RST);
  assign dovw_fix = ttfm_l11_fix(DOV_WARN_RST);
  assign duvw_fix = ttfm_l11_fix(DUV_WARN_RST);
  assign duvf_fix = ttfm_l11_fix(DUV_FLT_RST);

  // Warning comparisons, strict crossings
  assign otw_hit = t_fix > otw_fix;
  assign utw_hit = t_fix < utw_fix;
  assign dovw_hit = d_fix > dovw_fix;
  assign duvw_hit = d_fix < duvw_fix;

  // Fault trip at the limit, release past the warning level
  assign flt_set[F_UT] = t_fix <= utf_fix;
  assign flt_clr[F_UT] = t_fix > utw_fix;
  assign flt_set[F_OT] = t_fix >= otf_fix;
  assign flt_clr[F_OT] = t_fix < otw_fix;
  assign flt_set[F_DOV] = d_fix >= dovf_fix;
  assign flt_clr[F_DOV] = d_fix < dovw_fix;
  assign flt_set[F_DUV] = d_fix <= duvf_fix;
  assign flt_clr[F_DUV] = d_fix > duvw_fix;

  // Policy per channel; driver channels have fixed no-retry policy
  assign pol[F_UT] = ut_pol_reg;
  assign pol[F_OT] = ot_pol_reg;
  assign pol[F_DOV] = DRV_OV_POL_RST;
  assign pol[F_DUV] = DRV_UV_POL_RST;

  // One hysteresis flag and one sequencer per fault channel
  genvar gi;
  generate
    for (gi = 0; gi < NFLT; gi++) begin : g_flt
      ttfm_hyst_flag u_flag (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .upd(meas_valid),
        .set_cond(flt_set[gi]),
        .clr_cond(flt_clr[gi]),
        .flag(fault_active[gi])
      );
      ttfm_retry_ctl #(
        .UNIT_CYC(RETRY_UNIT_CYC),
        .CNT_W(CNT_W)
      ) u_retry (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run_en(run_en),
        .fault(fault_active[gi]),
        .other_blk(|(blk & ~(NFLT'(1) << gi))),
        .policy(pol[gi]),
        .run_ok(run_ok[gi]),
        .blocking(blk[gi])
      );
    end
  endgenerate

  // Output stays off while any channel withholds permission
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_en <= 1'b0;
    end else if (ce) begin
      output_en <= run_en && (&run_ok);
    end
  end

  // Status events; warnings only on a fresh sample
  always_comb begin
    temp_ev = '0;
    temp_ev[ST_OTW] = meas_valid && otw_hit;
    temp_ev[ST_UTW] = meas_valid && utw_hit;
    temp_ev[ST_OTF] = fault_active[F_OT];
    temp_ev[ST_UTF] = fault_active[F_UT];
    drv_ev = '0;
    drv_ev[SD_OVW] = meas_valid && dovw_hit;
    drv_ev[SD_UVW] = meas_valid && duvw_hit;
    drv_ev[SD_OVF] = fault_active[F_DOV];
    drv_ev[SD_UVF] = fault_active[F_DUV];
  end

  assign clr_cmd = cmd.wr && cmd.code == CMD_CLEAR;

  // Sticky bits; a new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_temp_reg <= '0;
      st_drv_reg <= '0;
    end else if (ce) begin
      st_temp_reg <= (clr_cmd ? ST_W'(0) : st_temp_reg) | temp_ev;
      st_drv_reg <= (clr_cmd ? ST_W'(0) : st_drv_reg) | drv_ev;
    end
  end

  // Word summary, rebuilt from the sticky bits
  always_comb begin
    status_word = '0;
    status_word[SW_TEMP] = |st_temp_reg;
    status_word[SW_NONE] = |st_drv_reg;
    status_word[SW_INPUT] = st_drv_reg[SD_OVW];
    status_word[SW_DRV] = st_drv_reg[SD_UVW] | st_drv_reg[SD_UVF];
  end

  // Alert follows the sticky bits one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_reg <= 1'b0;
    end else if (ce) begin
      alert_reg <= (|st_temp_reg) | (|st_drv_reg);
    end
  end
  assign alert_n = ~alert_reg;

  // Writable thresholds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      otw_reg <= OTW_RST;
      utw_reg <= UTW_RST;
      utf_reg <= UTF_RST;
    end else if (ce && cmd.wr) begin
      if (cmd.code == CMD_OTW) otw_reg <= cmd.wdata;
      if (cmd.code == CMD_UTW) utw_reg <= cmd.wdata;
      if (cmd.code == CMD_UTF) utf_reg <= cmd.wdata;
    end
  end

  // Policy bytes; reserved pair forced so reads stay consistent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ut_pol_reg <= UT_POL_RST;
      ot_pol_reg <= OT_POL_RST;
    end else if (ce && cmd.wr) begin
      if (cmd.code == CMD_UT_POL) ut_pol_reg <= ttfm_pol_wr(cmd.wdata[7:0]);
      if (cmd.code == CMD_OT_POL) ot_pol_reg <= ttfm_pol_wr(cmd.wdata[7:0]);
    end
  end

  // Read decode; read-only limits come straight from constants
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (cmd.code)
      CMD_OT_POL: rd_val = 16'(ot_pol_reg);
      CMD_OTW: rd_val = otw_reg;
      CMD_UTW: rd_val = utw_reg;
      CMD_UTF: rd_val = utf_reg;
      CMD_UT_POL: rd_val = 16'(ut_pol_reg);
      CMD_DOV_FLT: rd_val = DOV_FLT_RST;
      CMD_DOV_POL: rd_val = 16'(DRV_OV_POL_RST);
      CMD_DOV_WARN: rd_val = DOV_WARN_RST;
      CMD_DUV_WARN: rd_val = DUV_WARN_RST;
      CMD_DUV_FLT: rd_val = DUV_FLT_RST;
      CMD_DUV_POL: rd_val = 16'(DRV_UV_POL_RST);
      CMD_STATUS_WORD: rd_val = status_word;
      CMD_STATUS_TEMP: rd_val = 16'(st_temp_reg);
      CMD_STATUS_DRV: rd_val = 16'(st_drv_reg);
      default: rd_hit = 1'b0;
    endcase
  end

  // Writes to fixed limits are refused, not silently taken
  assign wr_ok = cmd.code inside {CMD_CLEAR, CMD_OT_POL, CMD_OTW, CMD_UTW,
                                  CMD_UTF, CMD_UT_POL};

  // Registered read data and refusal flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_rdata <= '0;
      cmd_nack <= 1'b0;
    end else if (ce) begin
      if (cmd.rd) cmd_rdata <= rd_val;
      cmd_nack <= (cmd.rd && !rd_hit) || (cmd.wr && !wr_ok);
    end
  end

  chk_policy_rsvd: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.wr && cmd.code == CMD_UT_POL)
      |=> (ut_pol_reg.rsvd == POL_RSVD
           && ut_pol_reg.retry == $past(cmd.wdata[5:3])))
    else $error("policy reserved bits not 10");

  chk_otw_status: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && meas_valid && otw_hit)
      |=> (st_temp_reg[ST_OTW] && status_word[SW_TEMP]))
    else $error("over-temp warning not flagged");

  chk_utw_status: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && meas_valid && utw_hit)
      |=> (st_temp_reg[ST_UTW] && status_word[SW_TEMP]))
    else $error("under-temp warning not flagged");

  chk_alert_follow: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && (|st_temp_reg || |st_drv_reg)) |=> !alert_n)
    else $error("alert not raised for status");

  chk_ut_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(fault_active[F_UT]) |-> $past(ce && meas_valid && t_fix > utw_fix))
    else $error("under-temp fault released early");

  chk_ut_policy: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && run_ok[F_UT] && run_en && fault_active[F_UT]
      && ut_pol_reg.retry != RETRY_ALWAYS) |=> ##1 !output_en)
    else $error("under-temp hold policy ignored");

  chk_ro_ovf: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.rd && cmd.code == CMD_DOV_FLT) |=> cmd_rdata == DOV_FLT_RST)
    else $error("overvoltage fault limit not fixed");

  chk_ro_ovpol: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.rd && cmd.code == CMD_DOV_POL)
      |=> cmd_rdata == 16'(DRV_OV_POL_RST))
    else $error("overvoltage policy not fixed");

  chk_drv_ovw: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && meas_valid && dovw_hit)
      |=> (st_drv_reg[SD_OVW] && status_word[SW_NONE]
           && status_word[SW_INPUT]))
    else $error("driver overvoltage warning not flagged");

  chk_drv_uvw: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && meas_valid && duvw_hit)
      |=> (st_drv_reg[SD_UVW] && status_word[SW_NONE]
           && status_word[SW_DRV]))
    else $error("driver undervoltage warning not flagged");

  chk_duv_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(fault_active[F_DUV]) |-> $past(ce && meas_valid && d_fix > duvw_fix))
    else $error("driver undervoltage fault released early");

  chk_ro_uvf: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.wr && cmd.code == CMD_DUV_FLT) |=> cmd_nack)
    else $error("write to fixed undervoltage limit taken");

  chk_ot_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(fault_active[F_OT]) |-> $past(ce && meas_valid && t_fix < otw_fix))
    else $error("over-temp fault released early");

  chk_fault_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && |blk) |=> !output_en)
    else $error("output enabled while a channel holds off");

  chk_ut_retry: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && run_ok[F_UT] && run_en && fault_active[F_UT]
      && ut_pol_reg.retry == RETRY_ALWAYS) |=> ##1 !output_en)
    else $error("under-temp retry policy ignored");

  chk_ro_ovw: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.rd && cmd.code == CMD_DOV_WARN)
      |=> cmd_rdata == DOV_WARN_RST)
    else $error("overvoltage warning limit not fixed");

  chk_ro_uvw: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.rd && cmd.code == CMD_DUV_WARN)
      |=> cmd_rdata == DUV_WARN_RST)
    else $error("undervoltage warning limit not fixed");

  chk_ro_uvf_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && cmd.rd && cmd.code == CMD_DUV_FLT)
      |=> cmd_rdata == DUV_FLT_RST)
    else $error("undervoltage fault limit not fixed");

  chk_status_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && clr_cmd && temp_ev == '0 && drv_ev == '0)
      |=> (st_temp_reg == '0 && st_drv_reg == '0))
    else $error("status not cleared by clear command");

endmodule

`default_nettype wire

// file: hw/ttfm_pkg.sv
// Command codes, layouts, reset values and helpers for the limit monitor
`default_nettype none

package ttfm_pkg;

  // Command codes of the limit, policy and status registers
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_OT_POL = 8'h50;
  localparam logic [7:0] CMD_OTW = 8'h51;
  localparam logic [7:0] CMD_UTW = 8'h52;
  localparam logic [7:0] CMD_UTF = 8'h53;
  localparam logic [7:0] CMD_UT_POL = 8'h54;
  localparam logic [7:0] CMD_DOV_FLT = 8'h55;
  localparam logic [7:0] CMD_DOV_POL = 8'h56;
  localparam logic [7:0] CMD_DOV_WARN = 8'h57;
  localparam logic [7:0] CMD_DUV_WARN = 8'h58;
  localparam logic [7:0] CMD_DUV_FLT = 8'h59;
  localparam logic [7:0] CMD_DUV_POL = 8'h5A;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] CMD_STATUS_DRV = 8'h80;

  // Reset and fixed threshold codes, linear-11
  localparam logic [15:0] OTW_RST = 16'hEB48;
  localparam logic [15:0] UTW_RST = 16'hE580;
  localparam logic [15:0] UTF_RST = 16'hE4E0;
  localparam logic [15:0] DOV_FLT_RST = 16'hCB00;
  localparam logic [15:0] DOV_WARN_RST = 16'hCAC0;
  localparam logic [15:0] DUV_WARN_RST = 16'hCA40;
  localparam logic [15:0] DUV_FLT_RST = 16'hCA00;
  localparam logic [15:0] OT_FAULT_THR_DEF = 16'hEB98;

  // Linear-11 field positions
  localparam int L11_EXP_MSB = 15;
  localparam int L11_EXP_LSB = 11;
  localparam int L11_MANT_MSB = 10;
  localparam int FIX_W = 43;

  // Fault-response byte layout
  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] retry;
    logic [2:0] delay;
  } ttfm_policy_t;
  localparam logic [1:0] POL_RSVD = 2'h2;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;
  localparam ttfm_policy_t UT_POL_RST = 8'h80;
  localparam ttfm_policy_t OT_POL_RST = 8'h80;
  localparam ttfm_policy_t DRV_OV_POL_RST = 8'h80;
  localparam ttfm_policy_t DRV_UV_POL_RST = 8'h80;

  // Command port carrier
  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } ttfm_cmd_t;

  // Fault indices
  localparam int F_UT = 0;
  localparam int F_OT = 1;
  localparam int F_DOV = 2;
  localparam int F_DUV = 3;
  localparam int NFLT = 4;

  // Status bit positions
  localparam int ST_W = 8;
  localparam int ST_OTF = 7;
  localparam int ST_OTW = 6;
  localparam int ST_UTW = 5;
  localparam int ST_UTF = 4;
  localparam int SD_OVF = 7;
  localparam int SD_OVW = 6;
  localparam int SD_UVW = 5;
  localparam int SD_UVF = 4;
  localparam int SW_NONE = 0;
  localparam int SW_TEMP = 2;
  localparam int SW_DRV = 8;
  localparam int SW_INPUT = 13;

  // Retry timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RETRY_STEP_MS = 35;
  localparam int NS_PER_MS = 1000000;
  localparam int RETRY_UNIT_CYC_DEF = RETRY_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int RETRY_CNT_W = 24;

  // Retry controller states
  typedef enum logic [4:0] {
    RC_OFF = 5'h01,
    RC_ON = 5'h02,
    RC_HOLD = 5'h04,
    RC_WAIT = 5'h08,
    RC_STOP = 5'h10
  } ttfm_rc_state_t;

  // Linear-11 to fixed point scaled by two to the sixteenth
  function automatic logic signed [FIX_W-1:0] ttfm_l11_fix(
    input logic [15:0] v
  );
    logic signed [FIX_W-1:0] m;
    logic [4:0] sh;
    m = FIX_W'(signed'(v[L11_MANT_MSB:0]));
    sh = {~v[L11_EXP_MSB], v[L11_EXP_MSB-1:L11_EXP_LSB]};
    return m <<< sh;
  endfunction

  // Policy write with the reserved pair forced
  function automatic ttfm_policy_t ttfm_pol_wr(input logic [7:0] b);
    ttfm_policy_t p;
    p = b;
    p.rsvd = POL_RSVD;
    return p;
  endfunction

endpackage

`default_nettype wire

// file: hw/ttfm_retry_ctl.sv
// Fault response sequencer: hold off, or timed endless restart
`timescale 1ns/1ps
`default_nettype none

module ttfm_retry_ctl
  import ttfm_pkg::*;
#(
  parameter int UNIT_CYC = RETRY_UNIT_CYC_DEF, // Cycles per delay step
  parameter int CNT_W = RETRY_CNT_W // Delay counter width
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic run_en, // On command
  input wire logic fault, // Fault flag of this channel
  input wire logic other_blk, // Another channel has shut down
  input wire ttfm_policy_t policy, // Fault-response byte
  output logic run_ok, // Channel permits output
  output logic blocking // Channel holds output off
);

  ttfm_rc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, wait_total;
  logic [CNT_W-1:0] wait_len_reg, wait_lat_reg;
  logic retry_on;

  // Only 111 retries; unused codes act as no retry
  assign retry_on = policy.retry == RETRY_ALWAYS;
  assign wait_total = CNT_W'((int'(policy.delay) + 1) * UNIT_CYC);
  assign run_ok = state_reg == RC_ON;
  assign blocking = state_reg == RC_HOLD;

  // Next state; restart does not look at the fault again
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RC_OFF: begin
        if (run_en) state_next = RC_ON;
      end
      RC_ON: begin
        if (!run_en) state_next = RC_OFF;
        else if (fault && retry_on) state_next = RC_WAIT;
        else if (fault) state_next = RC_HOLD;
      end
      RC_HOLD: begin
        if (!run_en) state_next = RC_OFF;
        else if (!fault) state_next = RC_ON;
      end
      RC_WAIT: begin
        if (!run_en) state_next = RC_OFF;
        else if (other_blk) state_next = RC_STOP;
        else if (cnt_reg == '0) state_next = RC_ON;
      end
      RC_STOP: begin
        if (!run_en) state_next = RC_OFF;
      end
      default: state_next = RC_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= RC_OFF;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Delay latched at entry, so a policy rewrite waits for the next try
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (state_next == RC_WAIT && state_reg != RC_WAIT) begin
        cnt_reg <= wait_total - 1'b1;
      end else if (state_reg == RC_WAIT) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Wait length tracker for checking only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_len_reg <= '0;
      wait_lat_reg <= '0;
    end else if (ce) begin
      if (state_next == RC_WAIT && state_reg != RC_WAIT) begin
        wait_len_reg <= '0;
        wait_lat_reg <= wait_total;
      end else if (state_reg == RC_WAIT) begin
        wait_len_reg <= wait_len_reg + 1'b1;
      end
    end
  end

  chk_wait_len: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && state_reg == RC_WAIT && state_next == RC_ON)
      |-> wait_len_reg == wait_lat_reg - 1'b1)
    else $error("restart spacing wrong");

  chk_hold_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && state_reg == RC_HOLD && fault && run_en)
      |=> (state_reg == RC_HOLD && !run_ok))
    else $error("output came back while fault held");

  chk_no_retry: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && run_ok && run_en && fault && !retry_on) |=> blocking)
    else $error("non-retry code did not hold off");

  chk_retry_loop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && run_ok && run_en && fault && retry_on)
      |=> state_reg == RC_WAIT)
    else $error("endless retry did not restart wait");

  chk_retry_stop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (ce && state_reg == RC_WAIT && run_en && other_blk)
      |=> (state_reg == RC_STOP ##1 !run_ok))
    else $error("retry not stopped by other fault");

endmodule

`default_nettype wire

// file: tb/tb_temp_and_drive_fault_monitor.sv
// Self-checking bench for the limit monitor
`timescale 1ns/1ps
`default_nettype none

module tb_temp_and_drive_fault_monitor
  import ttfm_pkg::*;
;
  typedef struct packed {
    logic [1:0] k; // 0 read, 1 write, 2 sample
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] e;
    logic n;
  } ttfm_row_t;
  localparam ttfm_row_t ROWS [34] = '{
    '{0,8'h51,0,16'hEB48,0}, '{0,8'h52,0,16'hE580,0},
    '{0,8'h53,0,16'hE4E0,0}, '{0,8'h54,0,16'h0080,0},
    '{0,8'h50,0,16'h0080,0}, '{0,8'h55,0,16'hCB00,0},
    '{0,8'h56,0,16'h0080,0}, '{0,8'h57,0,16'hCAC0,0},
    '{0,8'h58,0,16'hCA40,0}, '{0,8'h59,0,16'hCA00,0},
    '{0,8'h5A,0,16'h0080,0}, '{0,8'h20,0,16'h0000,1},
    '{1,8'h55,16'h1234,0,1}, '{0,8'h55,0,16'hCB00,0},
    '{1,8'h54,16'h00FF,0,0}, '{0,8'h54,0,16'h00BF,0},
    '{1,8'h54,16'h0080,0,0}, '{2,16'hEB50,16'hCA80,0,0},
    '{0,8'h7D,0,16'h0040,0}, '{0,8'h79,0,16'h0004,0},
    '{1,8'h03,0,0,0}, '{2,16'hE560,16'hCA80,0,0},
    '{0,8'h7D,0,16'h0020,0}, '{1,8'h03,0,0,0},
    '{2,16'h0000,16'hCACD,0,0}, '{0,8'h80,0,16'h0040,0},
    '{0,8'h79,0,16'h2001,0}, '{1,8'h03,0,0,0},
    '{2,16'h0000,16'hCA20,0,0}, '{0,8'h80,0,16'h0020,0},
    '{0,8'h79,0,16'h0101,0}, '{1,8'h03,0,0,0},
    '{2,16'h0000,16'hCA80,0,0}, '{0,8'h79,0,16'h0000,0}};
  logic clk, sys_rst, ce, meas_valid, run_en;
  logic [15:0] temp_meas, drv_meas, cmd_rdata;
  logic cmd_nack, output_en, alert_n;
  logic [3:0] fault_active;
  ttfm_cmd_t cmd;
  int failures = 0;
  int check_count = 0;

  ttfm_monitor #(.RETRY_UNIT_CYC(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .cmd(cmd), .cmd_rdata(cmd_rdata), .cmd_nack(cmd_nack),
    .meas_valid(meas_valid), .temp_meas(temp_meas), .drv_meas(drv_meas),
    .run_en(run_en), .output_en(output_en), .fault_active(fault_active),
    .alert_n(alert_n));
  ttfm_host_model i_host (.clk(clk), .cmd(cmd), .cmd_rdata(cmd_rdata),
    .cmd_nack(cmd_nack));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare helpers, one per result width
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t flag %b want %b", $time, g, e);
    end
  endtask

  // One sample strobe, then wait until flags and output stage settle
  task automatic sample(input logic [15:0] t, input logic [15:0] d);
    @(posedge clk);
    meas_valid <= 1'b1;
    temp_meas <= t;
    drv_meas <= d;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: table rows, then faults, retry and reset by hand
  initial begin
    logic [15:0] r;
    logic n;
    int lo;
    int i;
    sys_rst = 1'b1;
    ce = 1'b1;
    meas_valid = 1'b0;
    temp_meas = 16'h0000;
    drv_meas = 16'hCA80;
    run_en = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ROWS[j]) begin
      if (ROWS[j].k == 2'd2) begin
        sample(ROWS[j].a, ROWS[j].b);
      end else begin
        i_host.xfer(ROWS[j].k[0], ROWS[j].a[7:0], ROWS[j].b, r, n);
        if (!ROWS[j].k[0]) chk16(r, ROWS[j].e);
        chk1(n, ROWS[j].n);
      end
    end
    // Under-temp trip, hysteresis, hold-off with retry code 000
    sample(16'hE4E0, 16'hCA80);
    chk1(fault_active[F_UT], 1'b1);
    chk1(output_en, 1'b0);
    chk1(alert_n, 1'b0);
    sample(16'hE530, 16'hCA80);
    chk1(fault_active[F_UT], 1'b1);
    chk1(output_en, 1'b0);
    sample(16'h0000, 16'hCA80);
    chk1(fault_active[F_UT], 1'b0);
    chk1(output_en, 1'b1);
    // Over-temp and driver undervoltage faults hold until past warning
    sample(16'hEB98, 16'hCA00);
    chk16({12'h000, fault_active}, 16'h000A);
    chk1(output_en, 1'b0);
    sample(16'hEB50, 16'hCA20);
    chk16({12'h000, fault_active}, 16'h000A);
    sample(16'h0000, 16'hCA80);
    chk16({12'h000, fault_active}, 16'h0000);
    chk1(output_en, 1'b1);
    // Endless retry, delay field 1: two units of four cycles, eight off
    i_host.xfer(1'b1, CMD_UT_POL, 16'h0039, r, n);
    sample(16'hE4E0, 16'hCA80);
    lo = 1;
    for (i = 0; i < 200 && !output_en; i++) begin
      @(posedge clk);
      #1;
      if (!output_en) lo++;
    end
    chk1(lo == 8, 1'b1);
    chk1(fault_active[F_UT], 1'b1);
    @(posedge clk);
    #1;
    chk1(output_en, 1'b0);
    // A driver fault during the wait stops the retrying for good
    sample(16'hE4E0, 16'hCA00);
    sample(16'hE4E0, 16'hCA80);
    lo = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (output_en) lo++;
    end
    chk1(lo == 0, 1'b1);
    @(posedge clk);
    run_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk1(output_en, 1'b0);
    sample(16'h0000, 16'hCA80);
    run_en <= 1'b1;
    // Mid-run reset restores the writable policy
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk1(output_en, 1'b0);
    i_host.xfer(1'b0, CMD_UT_POL, 16'h0000, r, n);
    chk16(r, 16'h0080);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// file: tb/ttfm_host_model.sv
// Host model: drives one command per call and samples its answer
`timescale 1ns/1ps
`default_nettype none

module ttfm_host_model
  import ttfm_pkg::*;
(
  input wire logic clk, // Clock
  output var ttfm_cmd_t cmd, // Command to the monitor
  input wire logic [15:0] cmd_rdata, // Read data
  input wire logic cmd_nack // Refusal pulse
);
  initial cmd = '0;

  // Strobe held one edge; answer is read once that edge has settled
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] r, output logic n);
    @(posedge clk);
    cmd <= '{c, w, !w, d};
    @(posedge clk);
    cmd <= '0;
    #1;
    r = cmd_rdata;
    n = cmd_nack;
  endtask
endmodule

`default_nettype wire
